/* rtl/clk_prescale.sv */
`include "wdog_cfg.svh"
`default_nettype none
module clk_prescale (
  input wire logic clk_i,    // system clock
  input wire logic rst_i,    // sync reset
  input wire logic bypass_i, // skip halving stage
  input wire logic div16_i,  // extra divide by 16
  output logic tick_o        // core/timer clock enable
);
  logic half;
  logic [3:0] pre;
  logic base;

  assign base = bypass_i | half;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half <= 1'b0;
    end else begin
      half <= ~half;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= 4'h0;
    end else if (base) begin
      pre <= pre + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= base & (~div16_i | (pre == `DIV16_TERM));
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_half_rate;
    @(posedge clk_i) disable iff (rst_i)
    !bypass_i && !$past(bypass_i) && !div16_i && tick_o |=> !tick_o;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("halved clock ticked twice");

  property p_full_rate;
    @(posedge clk_i) disable iff (rst_i)
    bypass_i && !div16_i && $past(bypass_i) && !$past(div16_i) |-> tick_o;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("bypassed clock missed a tick");

  property p_div16_gap;
    @(posedge clk_i) disable iff (rst_i)
    div16_i && $past(div16_i) && tick_o ##1 div16_i[*8] |-> !tick_o && !$past(tick_o);
  endproperty
  a_div16_gap: assert property (p_div16_gap) else $error("divide by 16 ticked too soon");
endmodule
`default_nettype wire

/* rtl/watchdog_and_clock_prescale.sv */
`include "wdog_cfg.svh"
`default_nettype none
module watchdog_and_clock_prescale #(
  parameter int CW = 12,
  parameter int WW = 6
) (
  input wire logic clk_i,                 // 20 MHz clock
  input wire logic rst_i,                 // power-on reset
  input wire wdog_pkg::wb_req_s wb_req_i, // wishbone request
  output logic [31:0] wb_dat_o,           // read data
  output logic wb_ack_o,                  // acknowledge
  input wire logic refresh_i,             // refresh instruction pulse
  input wire logic first_instr_i,         // first instruction pulse
  input wire logic stop_recovery_i,       // stop recovery pulse
  input wire logic halt_i,                // core halted
  input wire logic stop_i,                // core stopped
  input wire logic supply_low_i,          // supply under threshold
  input wire logic rc_tick_i,             // RC oscillator tick
  input wire logic xtal_tick_i,           // crystal pin tick
  input wire logic permanent_i,           // permanent watchdog option
  input wire logic otp_lock_i,            // test mode lock option
  input wire logic test_mode_req_i,       // test mode entry request
  output logic core_clk_en_o,             // core clock enable
  output logic timer_clk_net_o,           // timer clock enable
  output logic dev_reset_o,               // global device reset
  output logic reset_delay_o,             // reset delay trigger pulse
  output logic [15:0] restart_vec_o,      // restart address
  output logic flags_we_o,                // flag update pulse
  output wdog_pkg::cpu_flags_s flags_o,   // flag values
  output logic test_mode_en_o,            // test mode allowed
  output logic wdt_run_o                  // watchdog counting
);
  import wdog_pkg::*;

  logic por;
  logic sclk_en;
  logic div16;
  logic bypass;
  logic stop_flag;
  dog_mode_s mode;
  win_state_e win;
  logic [WW-1:0] win_cnt;
  logic wdt_en;
  logic [CW-1:0] cnt;
  logic [CW-1:0] term;
  logic wdt_tick;
  logic wdt_active;
  logic to_evt;
  logic req;
  logic wr;
  logic hit_stop_rec;
  logic hit_mode;
  logic hit_stat;
  logic wr_ok;

  assign por = rst_i | supply_low_i;

  // ----------------------------------------
  // clock prescaler
  // ----------------------------------------
  clk_prescale u_pre (
    .clk_i(clk_i),
    .rst_i(por),
    .bypass_i(bypass),
    .div16_i(div16),
    .tick_o(sclk_en)
  );

  assign core_clk_en_o = sclk_en;
  assign timer_clk_net_o = sclk_en;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign wr = req & wb_req_i.we & wb_ack_o & wb_req_i.sel[0];
  assign hit_stop_rec = wb_req_i.adr == {`STOP_REC_IDX, 2'h0};
  assign hit_mode = wb_req_i.adr == {`MODE_IDX, 2'h0};
  assign hit_stat = wb_req_i.adr == {`STAT_IDX, 2'h0};
  assign wr_ok = win != WIN_LOCK;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req & ~wb_ack_o) begin
      if (hit_stop_rec) begin
        wb_dat_o <= 32'({stop_flag, 7'h00});
      end else if (hit_stat) begin
        wb_dat_o <= 32'({cnt, 5'h00, wdt_active, win == WIN_LOCK, wdt_en});
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

  // ----------------------------------------
  // stop recovery register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (por | to_evt | stop_recovery_i) begin
      div16 <= 1'b0;
    end else if (wr & hit_stop_rec) begin
      div16 <= wb_req_i.dat[`STOP_REC_DIV16_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (por | (to_evt & ~stop_i)) begin
      bypass <= 1'b0;
    end else if (wr & hit_stop_rec) begin
      bypass <= wb_req_i.dat[`STOP_REC_BYPASS_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (por) begin
      stop_flag <= 1'b0;
    end else if (stop_recovery_i) begin
      stop_flag <= 1'b1;
    end
  end

  // ----------------------------------------
  // write window
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (por | to_evt | stop_recovery_i) begin
      win <= WIN_ARM;
      win_cnt <= '0;
    end else begin
      case (win)
        WIN_ARM: begin
          if (first_instr_i) begin
            win <= WIN_OPEN;
          end
        end
        WIN_OPEN: begin
          if (sclk_en) begin
            if (win_cnt == WW'(`WIN_CYCLES - 6'h1)) begin
              win <= WIN_LOCK;
            end else begin
              win_cnt <= win_cnt + WW'(1);
            end
          end
        end
        WIN_LOCK: begin
          win <= WIN_LOCK;
        end
        default: begin
          win <= WIN_LOCK;
        end
      endcase
    end
  end

  // ----------------------------------------
  // watchdog mode register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (por | (to_evt & ~stop_i)) begin
      mode <= `MODE_RST;
    end else if (wr & hit_mode & wr_ok) begin
      mode <= {3'h0, wb_req_i.dat[4:0]};
    end
  end

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  always_comb begin
    case (mode.tsel)
      2'h0: term = CW'(`TERM_256);
      2'h1: term = CW'(`TERM_512);
      2'h2: term = CW'(`TERM_1024);
      2'h3: term = CW'(`TERM_4096);
      default: term = CW'(`TERM_4096);
    endcase
  end

  // crystal ticks are selected with bit 4; counting goes on in stop only with stop_run, bit 3, or with permanent_i
  assign wdt_tick = mode.xtal_sel ? xtal_tick_i : rc_tick_i;
  assign wdt_active = wdt_en & (permanent_i
    | ((~halt_i | mode.halt_run) & (~stop_i | mode.stop_run)));
  assign to_evt = wdt_active & wdt_tick & (cnt == term) & ~refresh_i;
  assign wdt_run_o = wdt_active;

  always_ff @(posedge clk_i) begin
    if (por | to_evt) begin
      wdt_en <= permanent_i;
    end else if (refresh_i) begin
      wdt_en <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por | refresh_i | to_evt) begin
      cnt <= '0;
    end else if (wdt_active & wdt_tick) begin
      cnt <= cnt + CW'(1);
    end
  end

  // ----------------------------------------
  // reset and core side outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_reset_o <= 1'b1;
    end else begin
      dev_reset_o <= supply_low_i | to_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_delay_o <= 1'b0;
    end else begin
      reset_delay_o <= to_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_vec_o <= `RESTART_VEC;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_we_o <= 1'b0;
      flags_o <= '0;
    end else begin
      flags_we_o <= refresh_i;
      if (refresh_i) begin
        flags_o <= `REFRESH_FLAGS;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_mode_en_o <= 1'b0;
    end else begin
      test_mode_en_o <= test_mode_req_i & ~otp_lock_i;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (por);

  sequence s_last_win;
    win == WIN_OPEN && sclk_en && win_cnt == WW'(`WIN_CYCLES - 6'h1);
  endsequence

  sequence s_locked_write;
    win == WIN_LOCK && wr && hit_mode && !to_evt;
  endsequence

  property p_lock;
    s_last_win && !to_evt && !stop_recovery_i |=> win == WIN_LOCK ##1 (win == WIN_LOCK || $past(to_evt | stop_recovery_i));
  endproperty
  a_lock: assert property (p_lock) else $error("window did not lock");

  property p_locked;
    s_locked_write |=> $stable(mode);
  endproperty
  a_locked: assert property (p_locked) else $error("mode changed after lock");

  property p_div16_clr;
    stop_recovery_i || to_evt |=> !div16;
  endproperty
  a_div16_clr: assert property (p_div16_clr) else $error("divide bit not cleared");

  property p_refresh;
    refresh_i |=> wdt_en && cnt == '0 && flags_we_o;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh not taken");

  property p_timeout;
    to_evt |=> reset_delay_o && dev_reset_o && cnt == '0 ##1 !reset_delay_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out not signalled");

  property p_halt_hold;
    halt_i && !stop_i && !mode.halt_run && !permanent_i && !refresh_i |=> $stable(cnt);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counted in halt");

  property p_stop_hold;
    stop_i && !mode.stop_run && !permanent_i && !refresh_i |=> $stable(cnt);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counted in stop");

  property p_perm;
    permanent_i && wdt_en && wdt_tick && cnt != term && !refresh_i |=> cnt == $past(cnt) + CW'(1);
  endproperty
  a_perm: assert property (p_perm) else $error("permanent watchdog stalled");

  property p_stop_keep;
    to_evt && stop_i && !wr |=> mode == $past(mode) && bypass == $past(bypass);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop time-out cleared registers");

  property p_mode_read;
    wb_ack_o && hit_mode && !wb_req_i.we |-> wb_dat_o == 32'h0;
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode register readable");

  property p_supply;
    @(posedge clk_i) disable iff (rst_i)
    supply_low_i |=> dev_reset_o;
  endproperty
  a_supply: assert property (p_supply) else $error("low supply without reset");

  property p_otp;
    otp_lock_i |=> !test_mode_en_o;
  endproperty
  a_otp: assert property (p_otp) else $error("test mode not blocked");
endmodule
`default_nettype wire

/* rtl/wdog_cfg.svh */
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH

// ----------------------------------------
// register indices, byte address = index * 4
// ----------------------------------------
`define STOP_REC_IDX 6'h0B
`define MODE_IDX 6'h0F
`define STAT_IDX 6'h10

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define STOP_REC_DIV16_BIT 0
`define STOP_REC_BYPASS_BIT 1
`define STOP_REC_FLAG_BIT 7
`define MODE_RST 8'h0C

// ----------------------------------------
// timing
// ----------------------------------------
`define WIN_CYCLES 6'h3C
`define DIV16_TERM 4'hF
`define TERM_256 12'h0FF
`define TERM_512 12'h1FF
`define TERM_1024 12'h3FF
`define TERM_4096 12'hFFF
`define RESTART_VEC 16'h000C
`define REFRESH_FLAGS 3'h0

`endif

/* rtl/wdog_pkg.sv */
`default_nettype none
package wdog_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic [2:0] rsvd;
    logic xtal_sel;
    logic stop_run;
    logic halt_run;
    logic [1:0] tsel;
  } dog_mode_s;

  typedef struct packed {
    logic z;
    logic s;
    logic v;
  } cpu_flags_s;

  typedef enum logic [1:0] {WIN_ARM, WIN_OPEN, WIN_LOCK} win_state_e;

endpackage
`default_nettype wire

/* test/cpu_core_model.sv */
`default_nettype none
module cpu_core_model (
  input wire logic clk_i,       // system clock
  input wire logic dev_reset_i, // device reset
  output logic refresh_o,       // refresh pulse
  output logic first_instr_o,   // first instruction
  output logic stop_rec_o,      // stop recovery pulse
  output logic halt_o,          // core halted
  output logic stop_o           // core stopped
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] boot_cnt;
  initial begin
    {refresh_o, stop_rec_o, halt_o, stop_o} = 4'h0;
    boot_cnt = 2'h0;
  end
  // fetch restarts a few cycles after reset ends
  always @(posedge clk_i) begin
    first_instr_o <= 1'b0;
    if (dev_reset_i | stop_rec_o) begin
      boot_cnt <= 2'h3;
    end else if (boot_cnt != 2'h0) begin
      boot_cnt <= boot_cnt - 2'h1;
      first_instr_o <= (boot_cnt == 2'h1);
    end
  end
  task automatic refresh();
    refresh_o <= 1'b1;
    @(posedge clk_i);
    refresh_o <= 1'b0;
  endtask
  task automatic recover();
    stop_rec_o <= 1'b1;
    @(posedge clk_i);
    stop_rec_o <= 1'b0;
  endtask
  task automatic sleep(input logic h, input logic s);
    halt_o <= h;
    stop_o <= s;
  endtask
endmodule
`default_nettype wire

/* test/watchdog_and_clock_prescale_tb.sv */
`default_nettype none
module watchdog_and_clock_prescale_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdog_pkg::*;
  logic clk_i, rst_i, sup_low, rc_tick, xt_tick, perm, otp, tst_req;
  logic refresh, first, srec, halt, stop;
  logic wb_ack, core_en, tmr_en, dev_rst, rst_dly, flags_we, tst_en, wdt_run;
  logic [31:0] wb_dat, q;
  logic [15:0] vec;
  logic [1:0] rc_div;
  wb_req_s wb_req;
  cpu_flags_s flags;
  int err_total, total_checks, cyc_cnt;
  int per[4] = '{256, 512, 1024, 4096};
  watchdog_and_clock_prescale i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .refresh_i(refresh), .first_instr_i(first),
    .stop_recovery_i(srec), .halt_i(halt), .stop_i(stop), .supply_low_i(sup_low),
    .rc_tick_i(rc_tick), .xtal_tick_i(xt_tick), .permanent_i(perm), .otp_lock_i(otp),
    .test_mode_req_i(tst_req), .core_clk_en_o(core_en), .timer_clk_net_o(tmr_en),
    .dev_reset_o(dev_rst), .reset_delay_o(rst_dly), .restart_vec_o(vec),
    .flags_we_o(flags_we), .flags_o(flags), .test_mode_en_o(tst_en), .wdt_run_o(wdt_run));
  cpu_core_model i_core (.clk_i(clk_i), .dev_reset_i(dev_rst), .refresh_o(refresh),
    .first_instr_o(first), .stop_rec_o(srec), .halt_o(halt), .stop_o(stop));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // ticks and hang limit
  // ----------------------------------------
  always @(posedge clk_i) begin
    xt_tick <= ~xt_tick;
    rc_div <= rc_div + 2'h1;
    rc_tick <= (rc_div == 2'h3);
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      err_total++;
      stop_test();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask
  task automatic count_en(input int n, input int e, input string nm);
    int k;
    int t;
    k = 0;
    t = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (core_en === 1'b1) k++;
      if (tmr_en === 1'b1) t++;
    end
    chk(nm, 32'(e), 32'(k));
    chk({nm, " timer"}, 32'(e), 32'(t));
  endtask
  task automatic measure(input int e);
    int n;
    n = 0;
    i_core.refresh();
    while (dev_rst !== 1'b1 && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    chk("period", 32'(e), (n > e - 9 && n < e + 9) ? 32'(e) : 32'(n));
    chk("delay trigger", 32'h1, {31'h0, rst_dly});
    @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    {rst_i, sup_low, rc_tick, xt_tick, perm, otp, tst_req} = 7'h41;
    rc_div = 2'h0;
    wb_req = '0;
    err_total = 0;
    total_checks = 0;
    cyc_cnt = 0;
    repeat (3) @(posedge clk_i);
    chk("reset out", 32'h1, {31'h0, dev_rst});
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("vector", 32'h0000000C, {16'h0000, vec});
    chk("test enable", 32'h1, {31'h0, tst_en});
    otp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("test locked", 32'h0, {31'h0, tst_en});
    bus(1'b0, 8'h3C, 8'h00);
    chk("mode read", 32'h0, q);
    bus(1'b0, 8'h80, 8'h00);
    chk("unmapped", 32'h0, q);
    count_en(32, 16, "half rate");
    $display("test reset done");
    bus(1'b1, 8'h2C, 8'h02);
    count_en(32, 32, "bypass rate");
    bus(1'b1, 8'h2C, 8'h01);
    count_en(64, 2, "div16 rate");
    $display("test prescale done");
    i_core.refresh();
    @(posedge clk_i);
    chk("flag strobe", 32'h1, {31'h0, flags_we});
    chk("flags", 32'h0, {29'h0, flags});
    bus(1'b0, 8'h40, 8'h00);
    chk("enabled", 32'h1, q & 32'h1);
    measure(1024);
    count_en(32, 16, "div cleared");
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h3C, 8'h1C | 8'(c));
      measure(per[c] * 2);
    end
    $display("test periods done");
    repeat (140) @(posedge clk_i);
    bus(1'b1, 8'h3C, 8'h1F);
    bus(1'b0, 8'h40, 8'h00);
    chk("locked", 32'h2, q);
    measure(1024);
    $display("test window done");
    bus(1'b1, 8'h3C, 8'h18);
    bus(1'b1, 8'h2C, 8'h03);
    i_core.refresh();
    i_core.sleep(1'b1, 1'b0);
    repeat (2) @(posedge clk_i);
    chk("halt idle", 32'h0, {31'h0, wdt_run});
    perm <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("permanent", 32'h1, {31'h0, wdt_run});
    perm <= 1'b0;
    i_core.sleep(1'b0, 1'b1);
    repeat (2) @(posedge clk_i);
    chk("stop run", 32'h1, {31'h0, wdt_run});
    measure(512);
    i_core.sleep(1'b0, 1'b0);
    count_en(16, 16, "stop keeps bypass");
    $display("test sleep done");
    i_core.recover();
    bus(1'b0, 8'h2C, 8'h00);
    chk("stop flag", 32'h80, q);
    bus(1'b1, 8'h3C, 8'h00);
    i_core.refresh();
    i_core.sleep(1'b0, 1'b1);
    repeat (8) @(posedge clk_i);
    chk("stop idle", 32'h0, {31'h0, wdt_run});
    i_core.sleep(1'b0, 1'b0);
    sup_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("low supply", 32'h1, {31'h0, dev_rst});
    sup_low <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, 8'h2C, 8'h00);
    chk("flag cleared", 32'h0, q);
    $display("test supply done");
    stop_test();
  end
endmodule
`default_nettype wire
